// ===== core/irw_watchdog.sv
// Internal RC watchdog: Avalon-MM register slave, standby control, reset
`timescale 1ns/100ps
module irw_watchdog #(
    parameter int RC_DIV = irw_pkg::RC_DIV_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic STANDBY,
    output logic WDT_RESET,
    output logic RC_OSC_EN,
    output logic IRQ
);
    irw_cnt_if #(.CNT_W(irw_pkg::CNT_W), .SEL_W(irw_pkg::SEL_W)) cbus ();

    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [irw_pkg::EV_W-1:0] status_r;
    logic [irw_pkg::EV_W-1:0] status_nxt;
    logic [irw_pkg::EV_W-1:0] mask_r;
    logic [irw_pkg::EV_W-1:0] mask_nxt;
    logic irq_r;
    logic wdt_rst_r;
    logic [irw_pkg::RST_CNT_W-1:0] rst_cnt_r;
    logic [irw_pkg::RST_CNT_W-1:0] rst_cnt_nxt;
    logic osc_en_r;
    logic stby_d_r;
    irw_pkg::irw_gap_t gap_r;
    irw_pkg::irw_gap_t gap_nxt;
    logic [2:0] gap_cnt_r;
    logic [2:0] gap_cnt_nxt;

    // Bus decode
    wire wr_fire = AVS_WRITE & !wait_r & AVS_BYTEENABLE[0];
    wire [7:0] wbyte = AVS_WRITEDATA[7:0];
    wire sel_ctrl = (AVS_ADDRESS == irw_pkg::OFS_CTRL);
    wire sel_count = (AVS_ADDRESS == irw_pkg::OFS_COUNT);
    wire sel_status = (AVS_ADDRESS == irw_pkg::OFS_STATUS);
    wire sel_mask = (AVS_ADDRESS == irw_pkg::OFS_MASK);
    wire sel_kick = (AVS_ADDRESS == irw_pkg::OFS_KICK);
    wire wr_ctrl = wr_fire & sel_ctrl;
    wire wr_kick = wr_fire & sel_kick;

    // Control fields
    wire run = ctrl_r[irw_pkg::CTRL_RUN_BIT];
    wire [1:0] stby_mode = ctrl_r[irw_pkg::CTRL_STBY_HI:irw_pkg::CTRL_STBY_LO];
    wire mode_hold = (stby_mode == irw_pkg::STBY_HOLD);
    wire mode_stop = (stby_mode == irw_pkg::STBY_STOP);
    wire ovf = cbus.ovf;

    // Kick port stands for the immediate-move path; plain control writes never kick
    wire kick_fire = wr_kick & run & (wbyte == irw_pkg::KICK_VALUE);
    wire ctrl_load = (wr_ctrl | wr_kick) & !run;
    wire refused = wr_ctrl & run;

    // Standby handling
    wire stby_freeze = run & STANDBY & (mode_hold | mode_stop);
    wire stby_exit = stby_d_r & !STANDBY;
    wire keep_osc = (gap_r == irw_pkg::GAP_KEEP) |
                    ((gap_r == irw_pkg::GAP_COUNT) & STANDBY);
    wire osc_nxt = run & !(stby_freeze & !keep_osc) & !ovf;

    assign cbus.count_en = run & !stby_freeze;
    assign cbus.clear = !run | kick_fire;
    assign cbus.sel = ctrl_r[irw_pkg::CTRL_SEL_HI:irw_pkg::CTRL_SEL_LO];
    assign cbus.osc_en = osc_en_r;

    irw_rc_osc #(.DIV(RC_DIV)) u_osc (
        .clk(CLK),
        .rst_n(RESETN),
        .bus(cbus)
    );

    irw_wdt_counter #(.CNT_W(irw_pkg::CNT_W)) u_cnt (
        .clk(CLK),
        .rst_n(RESETN),
        .bus(cbus)
    );

    // Overflow wins over a software load in the same cycle
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ovf) begin
            ctrl_nxt = (ctrl_r & irw_pkg::CTRL_KEEP_MASK) | irw_pkg::CTRL_FLAG_MASK;
        end else if (ctrl_load) begin
            ctrl_nxt = wbyte;
        end
    end

    // Set wins over a write-one clear
    wire [irw_pkg::EV_W-1:0] ev_set = {refused, ovf};
    wire [irw_pkg::EV_W-1:0] w1c =
        (wr_fire & sel_status) ? wbyte[irw_pkg::EV_W-1:0] : '0;
    assign status_nxt = (status_r & ~w1c) | ev_set;
    assign mask_nxt = (wr_fire & sel_mask) ? wbyte[irw_pkg::EV_W-1:0] : mask_r;

    // Internal reset stretched so slow logic sees it
    assign rst_cnt_nxt = ovf ? irw_pkg::RST_CNT_W'(irw_pkg::RST_PULSE_CYC) :
                         (rst_cnt_r != '0) ? rst_cnt_r - 1'b1 : '0;

    // Gap tracker after a hold-mode standby exit
    always_comb begin
        gap_nxt = gap_r;
        gap_cnt_nxt = gap_cnt_r;
        case (gap_r)
            irw_pkg::GAP_IDLE: begin
                if (run & mode_hold & stby_exit) begin
                    gap_nxt = irw_pkg::GAP_COUNT;
                    gap_cnt_nxt = 3'h0;
                end
            end
            irw_pkg::GAP_COUNT: begin
                if (STANDBY) begin
                    gap_nxt = irw_pkg::GAP_KEEP;
                end else if (cbus.tick) begin
                    gap_cnt_nxt = gap_cnt_r + 3'h1;
                    if (gap_cnt_r == 3'(irw_pkg::HOLD_GAP_TICKS - 1)) begin
                        gap_nxt = irw_pkg::GAP_IDLE;
                    end
                end
            end
            irw_pkg::GAP_KEEP: begin
                if (stby_exit) begin
                    gap_nxt = irw_pkg::GAP_COUNT;
                    gap_cnt_nxt = 3'h0;
                end
            end
            default: begin
                gap_nxt = irw_pkg::GAP_IDLE;
            end
        endcase
        if (!run | !mode_hold) begin
            gap_nxt = irw_pkg::GAP_IDLE;
        end
    end

    wire [31:0] rd_mux =
        sel_ctrl ? {24'h000000, ctrl_r} :
        sel_count ? {16'h0000, cbus.count} :
        sel_status ? {30'h00000000, status_r} :
        sel_mask ? {30'h00000000, mask_r} : 32'h00000000;

    // One wait cycle per access; read data sampled with the request
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            wait_r <= !((AVS_READ | AVS_WRITE) & wait_r);
            rdata_r <= (AVS_READ & wait_r) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= irw_pkg::CTRL_RESET;
            status_r <= irw_pkg::STATUS_RESET;
            mask_r <= irw_pkg::MASK_RESET;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(status_nxt & mask_nxt);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_cnt_r <= '0;
            wdt_rst_r <= 1'b0;
            osc_en_r <= 1'b0;
            stby_d_r <= 1'b0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            wdt_rst_r <= (rst_cnt_nxt != '0);
            osc_en_r <= osc_nxt;
            stby_d_r <= STANDBY;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            gap_r <= irw_pkg::GAP_IDLE;
            gap_cnt_r <= 3'h0;
        end else begin
            gap_r <= gap_nxt;
            gap_cnt_r <= gap_cnt_nxt;
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign WDT_RESET = wdt_rst_r;
    assign RC_OSC_EN = osc_en_r;
    assign IRQ = irq_r;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_ovf_flags;
        ctrl_r[7] && !ctrl_r[irw_pkg::CTRL_RUN_BIT] && !ctrl_r[6];
    endsequence

    sequence s_rst_held;
        WDT_RESET [*8] ##1 !WDT_RESET;
    endsequence

    sequence s_kick_seen;
        run && wr_kick && wbyte == irw_pkg::KICK_VALUE;
    endsequence

    sequence s_bus_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence

    // Overflow and what it leaves behind
    a_ovf_effects: assert property (
        ovf |=> s_ovf_flags ##0 s_rst_held) else $error("overflow effects wrong");

    a_ovf_keep_low: assert property (
        ovf |=> ctrl_r[4:0] == $past(ctrl_r[4:0])) else $error("low bits lost");

    a_ovf_count_zero: assert property (
        ovf |=> cbus.count == 16'h0000 [*2]) else $error("count not zero");

    a_rst_from_ovf: assert property (
        $rose(WDT_RESET) |-> $past(ovf)) else $error("reset without overflow");

    a_flag_source: assert property (
        $rose(ctrl_r[7]) |-> $past(ovf || ctrl_load)) else $error("flag set from nowhere");

    a_count_idle: assert property (
        !run |=> cbus.count == 16'h0000) else $error("count moves while stopped");

    // Register writes
    a_write_blocked: assert property (
        (run && wr_ctrl && !ovf) |=> $stable(ctrl_r)) else $error("write while running");

    a_refused_flag: assert property (
        refused |=> status_r[irw_pkg::EV_REFUSED]) else $error("refusal not flagged");

    a_kick_no_load: assert property (
        (run && wr_kick && !ovf) |=> $stable(ctrl_r)) else $error("kick loaded control");

    a_kick_clears: assert property (
        (run && wr_kick && wbyte == 8'h55) |=> cbus.count == 16'h0000)
        else $error("kick ignored");

    a_kick_restart: assert property (
        s_kick_seen |=> ##1 cbus.count <= 16'h0001) else $error("count not restarted");

    a_plain_no_clear: assert property (
        (run && wr_ctrl) |-> !cbus.clear) else $error("plain write cleared");

    a_flag_write: assert property (
        (!run && wr_ctrl && !ovf) |=> ctrl_r == $past(wbyte)) else $error("load lost");

    a_mask_write: assert property (
        (wr_fire && sel_mask) |=> mask_r == $past(wbyte[irw_pkg::EV_W-1:0]))
        else $error("mask write lost");

    a_w1c_clears: assert property (
        (wr_fire && sel_status && !ovf) |=>
        (status_r & $past(wbyte[irw_pkg::EV_W-1:0])) == 2'h0) else $error("status not cleared");

    a_set_wins: assert property (
        (ovf && wr_fire && sel_status && wbyte[0]) |=> status_r[0])
        else $error("event lost on clear");

    a_irq_level: assert property (
        IRQ == |(status_r & mask_r)) else $error("interrupt level wrong");

    // Oscillator and standby
    a_osc_follows_run: assert property (
        !run |=> !RC_OSC_EN) else $error("oscillator runs stopped");

    a_osc_starts: assert property (
        (run && !STANDBY && !ovf) |=> RC_OSC_EN) else $error("oscillator not started");

    a_hold_freeze: assert property (
        (run && mode_hold && STANDBY) |-> !cbus.count_en ##1 $stable(cbus.count))
        else $error("hold count moved");

    a_hold_osc_off: assert property (
        (run && mode_hold && STANDBY && gap_r == irw_pkg::GAP_IDLE && !ovf) |=> !RC_OSC_EN)
        else $error("hold oscillator on");

    a_hold_resume: assert property (
        (run && mode_hold && !STANDBY && !ovf) |-> cbus.count_en ##1 RC_OSC_EN)
        else $error("hold not resumed");

    a_gap_keep: assert property (
        (gap_r == irw_pkg::GAP_COUNT && STANDBY && run && mode_hold && !ovf) |=>
        RC_OSC_EN && gap_r == irw_pkg::GAP_KEEP) else $error("gap keep lost");

    a_gap_idle_stopped: assert property (
        !run |=> gap_r == irw_pkg::GAP_IDLE) else $error("gap tracker not idle");

    a_stby_codes: assert property (
        (run && STANDBY && (stby_mode == 2'h0 || stby_mode == 2'h3)) |-> cbus.count_en)
        else $error("continue mode stopped");

    a_stop_mode: assert property (
        (run && STANDBY && mode_stop) |-> !cbus.count_en) else $error("stop mode counts");

    a_stop_osc_off: assert property (
        (run && STANDBY && mode_stop && !ovf) |=> !RC_OSC_EN) else $error("stop mode osc on");

    // Bus handshake
    a_bus_answer: assert property (
        ($rose(AVS_READ) || $rose(AVS_WRITE)) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus not answered");

    a_bus_taken: assert property (
        s_bus_taken |=> !AVS_WAITREQUEST) else $error("taken request not answered");

    a_wait_one: assert property (
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("answer longer than one cycle");

    a_rdata_quiet: assert property (
        AVS_WAITREQUEST |-> AVS_READDATA == 32'h00000000) else $error("read data not quiet");
endmodule : irw_watchdog

// ===== core/irw_pkg.sv
// Package: constants and types of the internal RC watchdog
package irw_pkg;
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int RC_FREQ_HZ = 30_000;
    localparam int RC_DIV_CYC = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam int CNT_W = 16;
    localparam int SEL_W = 3;
    localparam int LIMIT_BASE_LOG2 = 9;
    localparam int HOLD_GAP_TICKS = 4;
    localparam int RST_PULSE_CYC = 8;
    localparam int RST_CNT_W = 4;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_KICK = 8'h10;
    localparam int CTRL_RUN_BIT = 5;
    localparam int CTRL_STBY_HI = 4;
    localparam int CTRL_STBY_LO = 3;
    localparam int CTRL_SEL_HI = 2;
    localparam int CTRL_SEL_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_KEEP_MASK = 8'h1f;
    localparam logic [7:0] CTRL_FLAG_MASK = 8'h80;
    localparam logic [7:0] KICK_VALUE = 8'h55;
    localparam logic [1:0] STBY_CONT0 = 2'h0;
    localparam logic [1:0] STBY_STOP = 2'h1;
    localparam logic [1:0] STBY_HOLD = 2'h2;
    localparam logic [1:0] STBY_CONT1 = 2'h3;
    localparam int EV_W = 2;
    localparam int EV_OVF = 0;
    localparam int EV_REFUSED = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    typedef enum logic [1:0] {GAP_IDLE, GAP_COUNT, GAP_KEEP} irw_gap_t;
endpackage : irw_pkg

// ===== core/irw_cnt_if.sv
// Interface: oscillator, counter and control signals of the watchdog
`timescale 1ns/100ps
interface irw_cnt_if #(parameter int CNT_W = 16, parameter int SEL_W = 3);
    logic osc_en;
    logic tick;
    logic count_en;
    logic clear;
    logic [SEL_W-1:0] sel;
    logic [CNT_W-1:0] count;
    logic ovf;
    modport ctl (output osc_en, output count_en, output clear, output sel,
                 input tick, input count, input ovf);
    modport osc (input osc_en, output tick);
    modport cnt (input tick, input count_en, input clear, input sel,
                 output count, output ovf);
endinterface : irw_cnt_if

// ===== core/irw_rc_osc.sv
// Low-speed RC oscillator model: tick enable divided from the system clock
`timescale 1ns/100ps
module irw_rc_osc #(
    parameter int DIV = irw_pkg::RC_DIV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    irw_cnt_if.osc bus
);
    localparam int DW = $clog2(DIV + 1);
    logic [DW-1:0] div_r;
    logic tick_r;

    // Stopped oscillator restarts with a whole period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (!bus.osc_en) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (div_r == DW'(DIV - 1)) begin
            div_r <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end
    assign bus.tick = tick_r;

    a_tick_needs_osc: assert property (@(posedge clk) disable iff (!rst_n)
        bus.tick |-> $past(bus.osc_en)) else $error("tick without oscillator");
endmodule : irw_rc_osc

// ===== core/irw_wdt_counter.sv
// Watchdog up-counter with selectable overflow count
`timescale 1ns/100ps
module irw_wdt_counter #(
    parameter int CNT_W = irw_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    irw_cnt_if.cnt bus
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire [CNT_W:0] limit = (CNT_W + 1)'(1) << (irw_pkg::LIMIT_BASE_LOG2 + int'(bus.sel));
    wire [CNT_W:0] limit_m1 = limit - 1'b1;
    wire step = bus.tick & bus.count_en & !bus.clear;
    wire hit = step & (cnt_r == limit_m1[CNT_W-1:0]);

    assign cnt_nxt = (bus.clear | hit) ? '0 : (step ? cnt_r + 1'b1 : cnt_r);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign bus.count = cnt_r;
    assign bus.ovf = hit;

    a_ovf_at_limit: assert property (@(posedge clk) disable iff (!rst_n)
        bus.ovf |-> (32'(bus.count) + 1 == 32'(limit))) else $error("overflow off limit");
    a_count_rc_only: assert property (@(posedge clk) disable iff (!rst_n)
        (!bus.tick && !bus.clear) |=> $stable(bus.count)) else $error("count moved");
endmodule : irw_wdt_counter

// ===== verification/irw_cpu_model.sv
// CPU core model: Avalon-MM master and standby request
`timescale 1ns/100ps
module irw_cpu_model (
    input wire logic clk,
    input wire logic waitreq,
    input wire logic [31:0] rdata,
    output logic [7:0] addr,
    output logic rd,
    output logic wr,
    output logic [31:0] wdata,
    output logic [3:0] be,
    output logic stby
);
    initial begin
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'h1;
        stby = 1'b0;
    end
    task automatic xfer(input logic is_rd, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= is_rd;
        wr <= !is_rd;
        // Answer is read at the edge, before that edge updates it
        @(posedge clk);
        while (waitreq) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : xfer
    task automatic enter_standby();
        @(posedge clk);
        stby <= 1'b1;
    endtask : enter_standby
    // One-cycle exit, too short on purpose, to reach the keep-running case
    task automatic blip_standby();
        @(posedge clk);
        stby <= 1'b0;
        @(posedge clk);
        stby <= 1'b1;
    endtask : blip_standby
    // Long gap after exit so the oscillator can really stop next time
    task automatic leave_standby(input int div);
        @(posedge clk);
        stby <= 1'b0;
        repeat (6 * div + 4) @(posedge clk);
    endtask : leave_standby
endmodule : irw_cpu_model

// ===== verification/testbench.sv
// Self-checking testbench of the internal RC watchdog
`timescale 1ns/100ps
module testbench;
    localparam int DIV = 4;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic stby;
    logic [31:0] rdata;
    logic waitreq;
    logic wdt_rst;
    logic osc_en;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'h2a70c526;
    int i;
    int t;
    logic fz;
    logic [7:0] d;
    logic [31:0] q;
    logic [31:0] c1;
    always #4 CLK = ~CLK;
    irw_watchdog #(.RC_DIV(DIV)) u_dut (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .STANDBY(stby),
        .WDT_RESET(wdt_rst), .RC_OSC_EN(osc_en), .IRQ(irq));
    irw_cpu_model u_cpu (.clk(CLK), .waitreq(waitreq), .rdata(rdata), .addr(addr),
        .rd(rd), .wr(wr), .wdata(wdata), .be(be), .stby(stby));
    function automatic int ovf_ticks(input int sel);
        return 512 << sel;
    endfunction : ovf_ticks
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic rdr(input logic [7:0] a);
        u_cpu.xfer(1'b1, a, 32'h0, q);
    endtask : rdr
    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] dummy;
        u_cpu.xfer(1'b0, a, {24'h0, v}, dummy);
    endtask : wrr
    task automatic do_reset();
        @(posedge CLK);
        RESETN <= 1'b0;
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
    endtask : do_reset
    // Hang guard well above the longest overflow run
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        do_reset();
        for (i = 0; i < 6; i++) begin
            rdr(8'(i * 4));
            chk("reset_reg", 32'h0, q);
        end
        @(negedge CLK);
        chk("osc_idle", 32'h0, {31'h0, osc_en});
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'hdf;
            wrr(8'h00, d);
            rdr(8'h00);
            chk("ctrl_rw", {24'h0, d}, q);
        end
        wrr(8'h24, 8'h5a);
        rdr(8'h24);
        chk("unmapped", 32'h0, q);
        for (i = 0; i < 3; i++) begin
            d = 8'($random(seed)) & 8'h18;
            do_reset();
            wrr(8'h0c, 8'h01);
            wrr(8'h00, 8'h20 | d | 8'(i));
            t = 0;
            while (wdt_rst !== 1'b1 && t < 40000) begin
                @(negedge CLK);
                t++;
            end
            chk("ovf_time", 1, t >= ovf_ticks(i) * DIV - 4 && t <= ovf_ticks(i) * DIV + 12);
            t = 0;
            while (wdt_rst === 1'b1 && t < 40) begin
                @(negedge CLK);
                t++;
            end
            chk("rst_width", 32'd8, t);
            chk("irq_ovf", 32'h1, {31'h0, irq});
            rdr(8'h00);
            chk("ctrl_after", {24'h0, 8'h80 | d | 8'(i)}, q);
            rdr(8'h04);
            chk("count_after", 32'h0, q);
            wrr(8'h08, 8'h01);
            rdr(8'h08);
            chk("status_w1c", 32'h0, q);
            @(negedge CLK);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        do_reset();
        rdr(8'h00);
        chk("pin_reset", 32'h0, q);
        wrr(8'h0c, 8'h03);
        wrr(8'h00, 8'h27);
        repeat (60) @(posedge CLK);
        rdr(8'h04);
        c1 = q;
        wrr(8'h00, 8'h55);
        rdr(8'h00);
        chk("ctrl_locked", 32'h27, q);
        rdr(8'h04);
        chk("plain_55", 1, q >= c1 && c1 > 4);
        rdr(8'h08);
        chk("refused", 32'h2, q);
        chk("irq_refused", 32'h1, {31'h0, irq});
        wrr(8'h10, 8'h55);
        rdr(8'h04);
        chk("kick", 1, q <= 1);
        for (i = 0; i < 4; i++) begin
            fz = (i == 1 || i == 2);
            do_reset();
            wrr(8'h00, 8'h27 | 8'(i << 3));
            repeat (40) @(posedge CLK);
            u_cpu.enter_standby();
            repeat (3) @(posedge CLK);
            rdr(8'h04);
            c1 = q;
            repeat (40) @(posedge CLK);
            rdr(8'h04);
            @(negedge CLK);
            chk("stby_freeze", {31'h0, fz}, {31'h0, q == c1});
            chk("stby_osc", {31'h0, !fz}, {31'h0, osc_en});
            u_cpu.leave_standby(DIV);
            rdr(8'h04);
            @(negedge CLK);
            chk("resume", 1, q > c1 && osc_en === 1'b1);
            if (i == 2) begin
                u_cpu.enter_standby();
                repeat (20) @(posedge CLK);
                u_cpu.blip_standby();
                rdr(8'h04);
                c1 = q;
                repeat (20) @(posedge CLK);
                rdr(8'h04);
                @(negedge CLK);
                chk("gap_keep", 1, osc_en === 1'b1 && q == c1);
                u_cpu.leave_standby(DIV);
            end
        end
        results();
    end
endmodule : testbench
